// *** src/hotplug_cfg.svh ***
// Constants for the hot-plug output sequencer: probe addresses and timing.
// Assumes a 100 MHz ref_clk; every count below is derived from that period.
`ifndef HOTPLUG_CFG_SVH
`define HOTPLUG_CFG_SVH

// Identification structure addresses on the display data channel
`define HP_ADDR_PRIMARY 8'ha2
`define HP_ADDR_LEGACY 8'ha0
`define HP_ADDR_NONE 8'h00

// Clock period and presence filter time, in ns
`define HP_CLK_PERIOD_NS 10
`define HP_FILT_TIME_NS 80

// Least time rounds up to whole cycles
`define HP_FILT_CYC ((`HP_FILT_TIME_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)

// Settle wait after reset or restart: filter time plus synchroniser depth
`define HP_SETTLE_CYC (`HP_FILT_CYC + 4)

// Counter width shared by filter and settle counters
`define HP_CNT_W 8

// Reset values of the output controls
`define HP_DAC_RESET 1'b0
`define HP_TX_RESET 1'b0

`endif

// *** src/hotplug_pkg.sv ***
// Types for the hot-plug output sequencer.
// Assumes nothing of its surroundings; constants live in hotplug_cfg.svh.
`default_nettype none
package hotplug_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_SETTLE    = 4'h0,
    ST_CHK_PWR   = 4'h1,
    ST_RD_PRI    = 4'h2,
    ST_RD_LEG    = 4'h3,
    ST_LOAD_RGB  = 4'h4,
    ST_LOAD_G    = 4'h5,
    ST_WS_TEST   = 4'h6,
    ST_CONFIG    = 4'h7,
    ST_RUN_ANA   = 4'h8,
    ST_RUN_DIG   = 4'h9,
    ST_DISC      = 4'ha,
    ST_ERR_WATCH = 4'hb
  } seq_state_e;

  // Kind of probe handed to the outside helpers
  typedef enum logic [2:0] {
    PK_NONE     = 3'h0,
    PK_ID_PRI   = 3'h1,
    PK_ID_LEG   = 3'h2,
    PK_LOAD_RGB = 3'h3,
    PK_LOAD_G   = 3'h4,
    PK_WS_TEST  = 3'h5
  } probe_kind_e;

  // What the sequence concluded about the attached monitor
  typedef enum logic [2:0] {
    MC_NONE       = 3'h0,
    MC_DIGITAL    = 3'h1,
    MC_ANA_ID     = 3'h2,
    MC_ANA_LEGACY = 3'h3,
    MC_COLOR_LOAD = 3'h4,
    MC_MONO_LOAD  = 3'h5,
    MC_DEFAULT    = 3'h6,
    MC_WORKSTN    = 3'h7
  } monitor_class_e;

endpackage
`default_nettype wire

// *** src/presence_filter.sv ***
// Presence comparator synchroniser and glitch filter.
// Assumes presenceRaw is an asynchronous comparator level (high = above threshold).
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_cfg.svh"

module presence_filter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Comparator level from the pin
  input wire logic presenceRaw,
  // Filtered level and its edges
  output logic presenceStable,
  output logic presenceRise,
  output logic presenceFall
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic stable_q;
  logic rise_q;
  logic fall_q;
  logic [`HP_CNT_W-1:0] cnt_q;
  logic [`HP_CNT_W-1:0] cnt_d;
  logic differs;
  logic flip;

  // Three-stage synchroniser; only stages two and three are compared
  always_ff @(posedge ref_clk) begin
    sync1_q <= presenceRaw;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  // A change counts once stages agree and hold for the filter time
  assign differs = (sync2_q == sync3_q) && (sync3_q != stable_q);
  assign flip = differs && (cnt_q == `HP_CNT_W'(`HP_FILT_CYC - 1));
  assign cnt_d = differs ? cnt_q + `HP_CNT_W'(1) : '0;

  // Stable level starts low so a present monitor shows as a rise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stable_q <= 1'b0;
      cnt_q <= '0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      cnt_q <= flip ? '0 : cnt_d;
      stable_q <= flip ? ~stable_q : stable_q;
      rise_q <= flip && !stable_q;
      fall_q <= flip && stable_q;
    end
  end

  assign presenceStable = stable_q;
  assign presenceRise = rise_q;
  assign presenceFall = fall_q;

endmodule // presence_filter
`default_nettype wire

// *** src/probe_handshake.sv ***
// Request and answer handshake towards the outside probe helpers.
// Assumes the helper answers each request with a one-cycle probeDone on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_cfg.svh"

module probe_handshake (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // From the sequencer
  input wire logic start,
  input wire hotplug_pkg::probe_kind_e kind,
  // To and from the helper
  output logic probeReq,
  output hotplug_pkg::probe_kind_e probeKind,
  output logic [7:0] probeAddr,
  input wire logic probeDone,
  input wire logic probeHit,
  input wire logic probeDigital,
  // Back to the sequencer
  output logic busy,
  output logic doneOut,
  output logic hitOut,
  output logic digitalOut
);
  import hotplug_pkg::*;

  logic req_q;
  logic busy_q;
  logic done_q;
  logic hit_q;
  logic dig_q;
  probe_kind_e kind_q;
  logic [7:0] addr_q;
  logic [7:0] addrSel;

  // Channel address only matters for identification reads
  assign addrSel = (kind == PK_ID_PRI) ? `HP_ADDR_PRIMARY :
                   (kind == PK_ID_LEG) ? `HP_ADDR_LEGACY : `HP_ADDR_NONE;

  // Kind and address stand from request until answer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      req_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      hit_q <= 1'b0;
      dig_q <= 1'b0;
      kind_q <= PK_NONE;
      addr_q <= `HP_ADDR_NONE;
    end else begin
      req_q <= start && !busy_q;
      done_q <= busy_q && probeDone;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        kind_q <= kind;
        addr_q <= addrSel;
      end else if (busy_q && probeDone) begin
        busy_q <= 1'b0;
        hit_q <= probeHit;
        dig_q <= probeDigital;
      end
    end
  end

  assign probeReq = req_q;
  assign probeKind = kind_q;
  assign probeAddr = addr_q;
  assign busy = busy_q;
  assign doneOut = done_q;
  assign hitOut = hit_q;
  assign digitalOut = dig_q;

endmodule // probe_handshake
`default_nettype wire

// *** src/host_hotplug_output_sequencer.sv ***
// Power-up and hot-plug sequencer for a host display output.
// Assumes one 100 MHz clock, outside helpers for channel reads and load sensing,
// and host software that configures timing and then pulses swCfgDone.
`timescale 1ns/1ps
`default_nettype none
`include "hotplug_cfg.svh"

// How it works
// - Dual host reads primary identification first
// - No primary identification means analogue monitor
// - Then read legacy identification, configure, enable
// - Else enable converters, sense all-three load
// - Else sense green; mono or default
// - Workstation runs its own loading test
// - Watch presence against threshold during operation
// - Analogue output keeps running without presence
// - Presence rise in analogue disables converters
// - Reconnect raises interrupt, sequence repeats
// - Digital-only host checks presence, then reads
// - Digital identification enables serial transmitter
// - Presence loss disables transmitter at once
// - Reconnect never re-enables transmitter by itself
// - Digital-only host flags error for analogue
// - Monitoring is hardware, independent of software
module host_hotplug_output_sequencer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Straps: host has analogue output too, host is a personal computer
  input wire logic dualOutputStrap,
  input wire logic pcHostStrap,
  // Presence comparator level, asynchronous
  input wire logic presenceRaw,
  // Probe helper handshake
  output logic probeReq,
  output hotplug_pkg::probe_kind_e probeKind,
  output logic [7:0] probeAddr,
  input wire logic probeDone,
  input wire logic probeHit,
  input wire logic probeDigital,
  // Software side
  input wire logic swCfgDone,
  output hotplug_pkg::monitor_class_e monitorClass,
  output logic cfgRequest,
  output logic errorStatus,
  output logic reconnectIrq,
  // Output stage enables
  output logic dacEnable,
  output logic txEnable
);
  import hotplug_pkg::*;

  seq_state_e state_q;
  seq_state_e state_d;
  monitor_class_e class_q;
  monitor_class_e class_d;
  logic dac_q;
  logic dac_d;
  logic tx_q;
  logic tx_d;
  logic err_q;
  logic err_d;
  logic irq_q;
  logic irq_d;
  logic cfgReq_q;
  logic issued_q;
  logic dual_q;
  logic pc_q;
  logic [`HP_CNT_W-1:0] settle_q;
  logic [1:0] strapRaw;
  logic [1:0] strapStable;
  logic presOk;
  logic presRise;
  logic presFall;
  logic pDone;
  logic pHit;
  logic pDig;
  logic pBusy;
  logic inProbe;
  logic startProbe;
  logic settled;
  logic restart;
  probe_kind_e kindSel;

  // Probe kind belongs to the state; decoded once and shared
  function automatic probe_kind_e kind_of(input seq_state_e s);
    case (s)
      ST_RD_PRI: kind_of = PK_ID_PRI;
      ST_RD_LEG: kind_of = PK_ID_LEG;
      ST_LOAD_RGB: kind_of = PK_LOAD_RGB;
      ST_LOAD_G: kind_of = PK_LOAD_G;
      ST_WS_TEST: kind_of = PK_WS_TEST;
      default: kind_of = PK_NONE;
    endcase
  endfunction

  // Analogue classes drive converters; only one class drives the transmitter
  function automatic logic is_analogue(input monitor_class_e c);
    is_analogue = (c != MC_DIGITAL) && (c != MC_NONE);
  endfunction

  // Dedicated presence monitor, runs regardless of software
  presence_filter u_presence (
    .ref_clk(ref_clk),
    .srst(srst),
    .presenceRaw(presenceRaw),
    .presenceStable(presOk),
    .presenceRise(presRise),
    .presenceFall(presFall)
  );

  probe_handshake u_probe (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(startProbe),
    .kind(kindSel),
    .probeReq(probeReq),
    .probeKind(probeKind),
    .probeAddr(probeAddr),
    .probeDone(probeDone),
    .probeHit(probeHit),
    .probeDigital(probeDigital),
    .busy(pBusy),
    .doneOut(pDone),
    .hitOut(pHit),
    .digitalOut(pDig)
  );

  // Straps come from pins, so each passes three synchroniser flip-flops and a hold flip-flop
  assign strapRaw = {pcHostStrap, dualOutputStrap};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_strap
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic held_q;
      always_ff @(posedge ref_clk) begin
        s1_q <= strapRaw[gi];
        s2_q <= s1_q;
        s3_q <= s2_q;
        held_q <= (s2_q == s3_q) ? s3_q : held_q; // Disagreeing stages keep the last level
      end
      assign strapStable[gi] = held_q;
    end
  endgenerate

  // Probe issue and settle decode
  assign kindSel = kind_of(state_q);
  assign inProbe = (kindSel != PK_NONE);
  assign startProbe = inProbe && !issued_q && !pBusy;
  assign settled = (settle_q == `HP_CNT_W'(`HP_SETTLE_CYC - 1));
  assign restart = (state_d == ST_SETTLE) && (state_q != ST_SETTLE);

  // Next-state and output decisions
  always_comb begin
    state_d = state_q;
    class_d = class_q;
    dac_d = dac_q;
    tx_d = tx_q;
    err_d = err_q;
    irq_d = 1'b0;
    case (state_q)
      ST_SETTLE: begin
        class_d = MC_NONE;
        err_d = 1'b0;
        if (settled) begin
          state_d = dual_q ? ST_RD_PRI : ST_CHK_PWR;
        end
      end
      ST_CHK_PWR: begin
        if (presOk) begin
          state_d = ST_RD_PRI;
        end else begin
          err_d = 1'b1;
          state_d = ST_ERR_WATCH;
        end
      end
      ST_RD_PRI: begin
        if (pDone) begin
          if (pHit && pDig) begin
            class_d = MC_DIGITAL;
            state_d = ST_CONFIG;
          end else if (!dual_q) begin
            err_d = 1'b1;
            state_d = ST_ERR_WATCH;
          end else if (pHit) begin
            class_d = MC_ANA_ID;
            state_d = ST_CONFIG;
          end else begin
            state_d = ST_RD_LEG;
          end
        end
      end
      ST_RD_LEG: begin
        if (pDone) begin
          if (pHit) begin
            class_d = MC_ANA_LEGACY;
            state_d = ST_CONFIG;
          end else if (pc_q) begin
            dac_d = 1'b1;
            state_d = ST_LOAD_RGB;
          end else begin
            state_d = ST_WS_TEST;
          end
        end
      end
      ST_LOAD_RGB: begin
        if (pDone) begin
          if (pHit) begin
            class_d = MC_COLOR_LOAD;
            state_d = ST_CONFIG;
          end else begin
            state_d = ST_LOAD_G;
          end
        end
      end
      ST_LOAD_G: begin
        if (pDone) begin
          class_d = pHit ? MC_MONO_LOAD : MC_DEFAULT;
          state_d = ST_CONFIG;
        end
      end
      ST_WS_TEST: begin
        if (pDone) begin
          class_d = MC_WORKSTN;
          state_d = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (swCfgDone) begin
          if (is_analogue(class_q)) begin
            dac_d = 1'b1;
            state_d = ST_RUN_ANA;
          end else if (presOk) begin
            tx_d = 1'b1;
            state_d = ST_RUN_DIG;
          end else begin
            state_d = ST_DISC;
          end
        end
      end
      ST_RUN_ANA: begin
        // A fall leaves the converters running
        if (presRise) begin
          dac_d = 1'b0;
          irq_d = 1'b1;
          state_d = ST_SETTLE;
        end
      end
      ST_RUN_DIG: begin
        if (!presOk) begin
          tx_d = 1'b0;
          state_d = ST_DISC;
        end
      end
      ST_DISC: begin
        if (presRise) begin
          irq_d = 1'b1;
          state_d = ST_SETTLE;
        end
      end
      ST_ERR_WATCH: begin
        if (presRise) begin
          irq_d = 1'b1;
          state_d = ST_SETTLE;
        end
      end
      default: begin
        dac_d = 1'b0;
        tx_d = 1'b0;
        state_d = ST_SETTLE;
      end
    endcase
  end

  // Sequencer state and output enables
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_SETTLE;
      class_q <= MC_NONE;
      dac_q <= `HP_DAC_RESET;
      tx_q <= `HP_TX_RESET;
      err_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      class_q <= class_d;
      dac_q <= dac_d;
      tx_q <= tx_d;
      err_q <= err_d;
      irq_q <= irq_d;
    end
  end

  // Settle counter reloads on every restart so the filter re-reads presence
  always_ff @(posedge ref_clk) begin
    if (srst || restart) begin
      settle_q <= '0;
    end else if (state_q == ST_SETTLE && !settled) begin
      settle_q <= settle_q + `HP_CNT_W'(1);
    end
  end

  // Straps caught while settling, after the release of reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dual_q <= 1'b0;
      pc_q <= 1'b0;
    end else if (state_q == ST_SETTLE) begin
      dual_q <= strapStable[0];
      pc_q <= strapStable[1];
    end
  end

  // One request per probe state; cleared when the answer comes back
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      issued_q <= 1'b0;
      cfgReq_q <= 1'b0;
    end else begin
      issued_q <= startProbe ? 1'b1 : (pDone ? 1'b0 : issued_q);
      cfgReq_q <= (state_d == ST_CONFIG);
    end
  end

  // Outputs straight from flip-flops
  assign monitorClass = class_q;
  assign cfgRequest = cfgReq_q;
  assign errorStatus = err_q;
  assign reconnectIrq = irq_q;
  assign dacEnable = dac_q;
  assign txEnable = tx_q;

endmodule // host_hotplug_output_sequencer
`default_nettype wire

// *** testbench/host_hotplug_output_sequencer_assertions.sv ***
// Port checker for the hot-plug output sequencer.
// Assumes one ref_clk domain and a synchronous, active-high srst.
`timescale 1ns/1ps
`default_nettype none
module host_hotplug_output_sequencer_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Inputs watched
  input wire logic dualOutputStrap,
  input wire logic presenceRaw,
  input wire logic swCfgDone,
  // Outputs watched
  input wire logic probeReq,
  input wire hotplug_pkg::probe_kind_e probeKind,
  input wire logic [7:0] probeAddr,
  input wire hotplug_pkg::monitor_class_e monitorClass,
  input wire logic cfgRequest,
  input wire logic errorStatus,
  input wire logic reconnectIrq,
  input wire logic dacEnable,
  input wire logic txEnable
);
  import hotplug_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [4:0] lowCnt_q;
  logic [4:0] hiCnt_q;
  // Pin history saturating at 16; cleared on reset so it never overstates
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lowCnt_q <= 5'h00;
      hiCnt_q <= 5'h00;
    end else begin
      lowCnt_q <= presenceRaw ? 5'h00 : ((lowCnt_q == 5'h10) ? lowCnt_q : lowCnt_q + 5'h01);
      hiCnt_q <= !presenceRaw ? 5'h00 : ((hiCnt_q == 5'h10) ? hiCnt_q : hiCnt_q + 5'h01);
    end
  end
  a_addr_primary: assert property (probeReq && probeKind == PK_ID_PRI |-> probeAddr == 8'ha2)
    else $error("primary probe has wrong address");
  a_addr_legacy: assert property (probeReq && probeKind == PK_ID_LEG |-> probeAddr == 8'ha0)
    else $error("legacy probe has wrong address");
  a_dac_before_load: assert property (probeReq && probeKind == PK_LOAD_RGB |-> ##[0:2] dacEnable)
    else $error("load sensing without converters on");
  a_tx_drop: assert property (lowCnt_q == 5'h10 |-> !txEnable)
    else $error("transmitter still on after presence loss");
  a_tx_rise_sw: assert property ($rose(txEnable) |-> $past(swCfgDone) && $past(cfgRequest))
    else $error("transmitter enabled without software go");
  a_tx_digital: assert property (txEnable |-> monitorClass == MC_DIGITAL)
    else $error("transmitter on for a non-digital class");
  a_dac_holds: assert property ($fell(dacEnable) |-> reconnectIrq)
    else $error("converters dropped without reconnect");
  a_irq_filtered: assert property (reconnectIrq |-> hiCnt_q >= 5'h08 ##1 !reconnectIrq)
    else $error("reconnect pulse without settled presence");
  a_irq_outputs_off: assert property (reconnectIrq |-> !dacEnable && !txEnable)
    else $error("outputs left on at reconnect");
  a_err_digital: assert property (errorStatus |-> !dualOutputStrap)
    else $error("error status on a dual-output host");
endmodule // host_hotplug_output_sequencer_assertions

bind host_hotplug_output_sequencer host_hotplug_output_sequencer_assertions i_chk (
  .ref_clk(ref_clk), .srst(srst), .dualOutputStrap(dualOutputStrap), .presenceRaw(presenceRaw),
  .swCfgDone(swCfgDone), .probeReq(probeReq), .probeKind(probeKind), .probeAddr(probeAddr),
  .monitorClass(monitorClass), .cfgRequest(cfgRequest), .errorStatus(errorStatus),
  .reconnectIrq(reconnectIrq), .dacEnable(dacEnable), .txEnable(txEnable));
`default_nettype wire

// *** testbench/probe_monitor.sv ***
// Model of the attached monitor behind the probe helper handshake.
// Assumes one probe outstanding at a time; answers after a set latency.
`timescale 1ns/1ps
`default_nettype none
module probe_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Probe request
  input wire logic probeReq,
  input wire hotplug_pkg::probe_kind_e probeKind,
  // Scenario controls
  input wire logic [5:0] hitMask,
  input wire logic digAns,
  input wire logic [4:0] latency,
  // Answer and log of kinds asked
  output logic probeDone,
  output logic probeHit,
  output logic probeDigital,
  output logic [11:0] kindLog
);
  import hotplug_pkg::*;
  logic busy_q;
  logic [4:0] waitCnt_q;
  probe_kind_e kind_q;
  // Defined levels before the first clock edge
  initial begin
    probeDone = 1'h0;
    probeHit = 1'h0;
    probeDigital = 1'h0;
  end
  // Between answers the result lines toggle, so stale values never look valid
  always @(posedge ref_clk) begin
    probeDone <= 1'h0;
    probeHit <= ~probeHit;
    probeDigital <= ~probeDigital;
    if (srst) begin
      busy_q <= 1'h0;
      kindLog <= 12'h000;
    end else if (probeReq) begin
      busy_q <= 1'h1;
      waitCnt_q <= latency;
      kind_q <= probeKind;
      kindLog <= {kindLog[8:0], probeKind};
    end else if (busy_q && waitCnt_q > 5'h01) begin
      waitCnt_q <= waitCnt_q - 5'h01;
    end else if (busy_q) begin
      busy_q <= 1'h0;
      probeDone <= 1'h1;
      probeHit <= hitMask[kind_q];
      probeDigital <= digAns && kind_q == PK_ID_PRI;
    end
  end
endmodule // probe_monitor
`default_nettype wire

// *** testbench/host_hotplug_output_sequencer_bench.sv ***
// Self-checking bench for the hot-plug output sequencer.
// Assumes the probe_monitor model answers probes; bench drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module host_hotplug_output_sequencer_bench;
  import hotplug_pkg::*;
  typedef struct packed {
    logic dual; logic pc; logic [5:0] hit; logic dig;
    monitor_class_e cls; logic err; logic dac; logic tx; logic [11:0] seq;
  } row_s;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic dualOutputStrap = 1'h1;
  logic pcHostStrap = 1'h1;
  logic presenceRaw = 1'h1;
  logic swCfgDone = 1'h0;
  logic [5:0] hitMask = 6'h00;
  logic digAns = 1'h0;
  logic [4:0] latency = 5'h01;
  logic probeReq, probeDone, probeHit, probeDigital, cfgRequest, errorStatus, reconnectIrq, dacEnable, txEnable;
  logic [7:0] probeAddr;
  logic [11:0] kindLog;
  probe_kind_e probeKind;
  monitor_class_e monitorClass;
  int errorCnt = 0;
  int checksDone = 0;
  int irqCnt = 0;
  int i;
  // Straps, expected class and outputs, expected order of probe kinds
  row_s rows [9] = '{
    '{1'h1, 1'h1, 6'h02, 1'h1, MC_DIGITAL, 1'h0, 1'h0, 1'h1, 12'h001},
    '{1'h1, 1'h1, 6'h02, 1'h0, MC_ANA_ID, 1'h0, 1'h1, 1'h0, 12'h001},
    '{1'h1, 1'h1, 6'h04, 1'h0, MC_ANA_LEGACY, 1'h0, 1'h1, 1'h0, 12'h00a},
    '{1'h1, 1'h1, 6'h08, 1'h0, MC_COLOR_LOAD, 1'h0, 1'h1, 1'h0, 12'h053},
    '{1'h1, 1'h1, 6'h10, 1'h0, MC_MONO_LOAD, 1'h0, 1'h1, 1'h0, 12'h29c},
    '{1'h1, 1'h1, 6'h00, 1'h0, MC_DEFAULT, 1'h0, 1'h1, 1'h0, 12'h29c},
    '{1'h1, 1'h0, 6'h00, 1'h0, MC_WORKSTN, 1'h0, 1'h1, 1'h0, 12'h055},
    '{1'h0, 1'h1, 6'h02, 1'h1, MC_DIGITAL, 1'h0, 1'h0, 1'h1, 12'h001},
    '{1'h0, 1'h1, 6'h02, 1'h0, MC_NONE, 1'h1, 1'h0, 1'h0, 12'h001}};

  host_hotplug_output_sequencer i_host_hotplug_output_sequencer (
    .ref_clk(ref_clk), .srst(srst), .dualOutputStrap(dualOutputStrap), .pcHostStrap(pcHostStrap),
    .presenceRaw(presenceRaw), .probeReq(probeReq), .probeKind(probeKind), .probeAddr(probeAddr),
    .probeDone(probeDone), .probeHit(probeHit), .probeDigital(probeDigital), .swCfgDone(swCfgDone),
    .monitorClass(monitorClass), .cfgRequest(cfgRequest), .errorStatus(errorStatus),
    .reconnectIrq(reconnectIrq), .dacEnable(dacEnable), .txEnable(txEnable));
  probe_monitor i_probe_monitor (
    .ref_clk(ref_clk), .srst(srst), .probeReq(probeReq), .probeKind(probeKind), .hitMask(hitMask),
    .digAns(digAns), .latency(latency), .probeDone(probeDone), .probeHit(probeHit),
    .probeDigital(probeDigital), .kindLog(kindLog));

  // Free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // Count reconnect pulses; old value is read, so no race with the design
  always @(posedge ref_clk) begin
    if (reconnectIrq === 1'h1) irqCnt++;
  end

  task automatic chk1(input string nm, input logic e, input logic g);
    checksDone++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errorCnt++;
    end
  endtask
  task automatic chkv(input string nm, input logic [11:0] e, input logic [11:0] g);
    checksDone++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errorCnt++;
    end
  endtask
  task automatic closeOut;
    if (errorCnt == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Bounded wait: 0 for end of probing, 1 for a new reconnect pulse
  task automatic waitFor(input int sel, input int lim);
    int n;
    int base;
    n = 0;
    base = irqCnt;
    while (n < lim && !(sel == 0 ? (cfgRequest === 1'h1 || errorStatus === 1'h1) : irqCnt != base)) begin
      ticks(1);
      n++;
    end
    if (n == lim) begin
      $display("[FAIL] wait %0d expected done seen timeout", sel);
      errorCnt++;
      closeOut;
    end
  endtask
  task automatic doReset(input logic d, input logic p);
    dualOutputStrap = d;
    pcHostStrap = p;
    srst = 1'h1;
    ticks(2);
    srst = 1'h0;
  endtask
  // One identification run; odd rows use a slow monitor
  task automatic doRow(input int k);
    row_s r;
    r = rows[k];
    hitMask = r.hit;
    digAns = r.dig;
    latency = k[0] ? 5'h10 : 5'h01;
    doReset(r.dual, r.pc);
    waitFor(0, 600);
    chkv("monitorClass", {9'h000, r.cls}, {9'h000, monitorClass});
    chk1("errorStatus", r.err, errorStatus);
    chkv("probe order", r.seq, kindLog);
    if (!r.err) begin
      swCfgDone = 1'h1;
      ticks(1);
      swCfgDone = 1'h0;
      ticks(1);
      chk1("dacEnable", r.dac, dacEnable);
      chk1("txEnable", r.tx, txEnable);
    end
  endtask

  // Main sequence
  initial begin
    ticks(1);
    chkv("outputs in reset", 12'h000, {probeAddr, dacEnable, txEnable, cfgRequest, errorStatus});
    chkv("more outputs in reset", 12'h000, {4'h0, probeReq, reconnectIrq, probeKind, monitorClass});
    for (i = 0; i < 9; i++) doRow(i);
    // Digital run: loss, short glitch, then reconnect
    doRow(0);
    presenceRaw = 1'h0;
    ticks(16);
    chk1("txEnable after loss", 1'h0, txEnable);
    i = irqCnt;
    presenceRaw = 1'h1;
    ticks(3);
    presenceRaw = 1'h0;
    ticks(20);
    chkv("pulses after glitch", 12'h000, 12'(irqCnt - i));
    presenceRaw = 1'h1;
    waitFor(1, 40);
    chk1("txEnable at reconnect", 1'h0, txEnable);
    ticks(2);
    chkv("class after restart", 12'h000, {9'h000, monitorClass});
    waitFor(0, 600);
    chkv("probe after restart", 12'h001, {9'h000, kindLog[2:0]});
    chk1("txEnable after restart", 1'h0, txEnable);
    // Digital class but monitor pulled before the go: wait unplugged, no transmitter
    presenceRaw = 1'h0;
    ticks(16);
    swCfgDone = 1'h1;
    ticks(1);
    swCfgDone = 1'h0;
    presenceRaw = 1'h1;
    waitFor(1, 40);
    chk1("txEnable unplugged at go", 1'h0, txEnable);
    // Analogue run: loss keeps converters, return drops them
    doRow(1);
    presenceRaw = 1'h0;
    ticks(30);
    chk1("dacEnable after loss", 1'h1, dacEnable);
    presenceRaw = 1'h1;
    waitFor(1, 40);
    chk1("dacEnable at reconnect", 1'h0, dacEnable);
    // Digital-only host that sees no presence at start
    presenceRaw = 1'h0;
    hitMask = 6'h02;
    digAns = 1'h1;
    doReset(1'h0, 1'h1);
    waitFor(0, 200);
    chk1("errorStatus no presence", 1'h1, errorStatus);
    chkv("probes without presence", 12'h000, kindLog);
    presenceRaw = 1'h1;
    waitFor(1, 40);
    ticks(3);
    chk1("errorStatus after restart", 1'h0, errorStatus);
    closeOut;
  end
endmodule // host_hotplug_output_sequencer_bench
`default_nettype wire
